// ---- logic/cuc_top.sv ----
`timescale 1ns/100ps
`include "cuc_params.svh"

module cuc_top #(
    parameter int CODE_W = 16,
    parameter int NCH = 16,
    parameter int ADDR_W = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic loadTrigger,
    output logic [NCH*CODE_W-1:0] chanOut,
    output logic broadcastBlocked
);

    if (NCH != 16 || CODE_W < 1 || CODE_W > 16 || ADDR_W < 8) begin : g_bad_params
        $error("cuc_top: unsupported parameters");
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus write side

    cuc_pkg::cuc_wr_e wrState_q, wrState_d;
    logic awHave_q, awHave_d, wHave_q, wHave_d;
    logic [5:0] awIdx_q, awIdx_d;
    logic [31:0] wData_q, wData_d;
    logic [3:0] wStrb_q, wStrb_d;
    logic [1:0] bResp_q, bResp_d;
    logic doWrite;
    logic [5:0] wrIdx;
    logic [31:0] wrData;
    logic [3:0] wrStrb;
    logic wrMapped;

    assign s_axi_awready = (wrState_q == cuc_pkg::CUC_WR_IDLE) && !awHave_q;
    assign s_axi_wready = (wrState_q == cuc_pkg::CUC_WR_IDLE) && !wHave_q;
    assign s_axi_bvalid = (wrState_q == cuc_pkg::CUC_WR_RESP);
    assign s_axi_bresp = bResp_q;

    always_comb begin
        wrState_d = wrState_q;
        awHave_d = awHave_q;
        wHave_d = wHave_q;
        awIdx_d = awIdx_q;
        wData_d = wData_q;
        wStrb_d = wStrb_q;
        bResp_d = bResp_q;
        wrIdx = awHave_q ? awIdx_q : s_axi_awaddr[7:2];
        wrData = wHave_q ? wData_q : s_axi_wdata;
        wrStrb = wHave_q ? wStrb_q : s_axi_wstrb;
        wrMapped = (wrIdx >= `CUC_IDX_DIFF && wrIdx <= `CUC_IDX_TOGU) ||
                   (wrIdx >= `CUC_IDX_LOAD && wrIdx <= `CUC_IDX_CH15);
        doWrite = 1'b0;
        case (wrState_q)
            cuc_pkg::CUC_WR_IDLE: begin
                if (s_axi_awvalid && s_axi_awready) begin
                    awHave_d = 1'b1;
                    awIdx_d = s_axi_awaddr[7:2];
                end
                if (s_axi_wvalid && s_axi_wready) begin
                    wHave_d = 1'b1;
                    wData_d = s_axi_wdata;
                    wStrb_d = s_axi_wstrb;
                end
                if (awHave_d && wHave_d) begin
                    doWrite = 1'b1;
                    awHave_d = 1'b0;
                    wHave_d = 1'b0;
                    bResp_d = wrMapped ? `CUC_RESP_OKAY : `CUC_RESP_DECERR;
                    wrState_d = cuc_pkg::CUC_WR_RESP;
                end
            end
            cuc_pkg::CUC_WR_RESP: begin
                if (s_axi_bready) begin
                    wrState_d = cuc_pkg::CUC_WR_IDLE;
                end
            end
            default: begin
                wrState_d = cuc_pkg::CUC_WR_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wrState_q <= cuc_pkg::CUC_WR_IDLE;
            awHave_q <= 1'b0;
            wHave_q <= 1'b0;
            awIdx_q <= 6'h00;
            wData_q <= 32'h0000_0000;
            wStrb_q <= 4'h0;
            bResp_q <= `CUC_RESP_OKAY;
        end else begin
            wrState_q <= wrState_d;
            awHave_q <= awHave_d;
            wHave_q <= wHave_d;
            awIdx_q <= awIdx_d;
            wData_q <= wData_d;
            wStrb_q <= wStrb_d;
            bResp_q <= bResp_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Configuration and channel state

    logic [7:0] pairDiff_q, pairDiff_d;
    cuc_pkg::cuc_chmask_t join_q, join_d, sync_q, sync_d, togU_q, togU_d;
    logic [15:0] bcastVal_q, bcastVal_d;
    logic [CODE_W-1:0] pend_q [NCH];
    logic [CODE_W-1:0] pend_d [NCH];
    logic [CODE_W-1:0] out_q [NCH];
    logic [CODE_W-1:0] out_d [NCH];
    logic [15:0] merged;
    logic [15:0] codeOld;
    logic loadNow;

    function automatic logic [15:0] lane_merge(input logic [15:0] old,
                                               input logic [31:0] data,
                                               input logic [3:0] strb);
        lane_merge = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
    endfunction

    assign broadcastBlocked = |pairDiff_q;

    always_comb begin
        pairDiff_d = pairDiff_q;
        join_d = join_q;
        sync_d = sync_q;
        togU_d = togU_q;
        bcastVal_d = bcastVal_q;
        pend_d = pend_q;
        out_d = out_q;
        merged = 16'h0000;
        codeOld = 16'h0000;
        loadNow = loadTrigger;
        if (doWrite) begin
            case (wrIdx)
                `CUC_IDX_DIFF: begin
                    merged = lane_merge({8'h00, pairDiff_q}, wrData, wrStrb);
                    pairDiff_d = merged[7:0];
                end
                `CUC_IDX_JOIN: join_d = lane_merge(join_q, wrData, wrStrb);
                `CUC_IDX_SYNC: sync_d = lane_merge(sync_q, wrData, wrStrb);
                `CUC_IDX_TOGU: togU_d = lane_merge(togU_q, wrData, wrStrb);
                `CUC_IDX_LOAD: loadNow = loadTrigger || (wrStrb[0] && wrData[`CUC_LOAD_BIT]);
                `CUC_IDX_BVAL: begin
                    merged = lane_merge(bcastVal_q, wrData, wrStrb);
                    bcastVal_d = merged;
                    if (!broadcastBlocked) begin
                        for (int n = 0; n < NCH; n++) begin
                            if (join_q[n]) begin
                                pend_d[n] = merged[CODE_W-1:0];
                                if (!sync_q[n]) begin
                                    out_d[n] = merged[CODE_W-1:0];
                                end
                            end
                        end
                    end
                end
                default: begin
                    if (wrIdx >= `CUC_IDX_CH0 && wrIdx <= `CUC_IDX_CH15) begin
                        codeOld[CODE_W-1:0] = pend_q[wrIdx[3:0]];
                        merged = lane_merge(codeOld, wrData, wrStrb);
                        pend_d[wrIdx[3:0]] = merged[CODE_W-1:0];
                        if (!sync_q[wrIdx[3:0]]) begin
                            out_d[wrIdx[3:0]] = merged[CODE_W-1:0];
                        end
                    end
                end
            endcase
        end
        if (loadNow) begin
            for (int n = 0; n < NCH; n++) begin
                if (sync_q[n]) begin
                    out_d[n] = pend_d[n];
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pairDiff_q <= `CUC_RST_DIFF;
            join_q <= `CUC_RST_JOIN;
            sync_q <= `CUC_RST_SYNC;
            togU_q <= `CUC_RST_TOGU;
            bcastVal_q <= 16'h0000;
            for (int n = 0; n < NCH; n++) begin
                pend_q[n] <= '0;
                out_q[n] <= '0;
            end
        end else begin
            pairDiff_q <= pairDiff_d;
            join_q <= join_d;
            sync_q <= sync_d;
            togU_q <= togU_d;
            bcastVal_q <= bcastVal_d;
            pend_q <= pend_d;
            out_q <= out_d;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_out
            assign chanOut[g*CODE_W +: CODE_W] = out_q[g];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Bus read side

    logic rValid_q, rValid_d;
    logic [31:0] rData_q, rData_d;
    logic [1:0] rResp_q, rResp_d;
    logic [5:0] rdIdx;

    assign s_axi_arready = !rValid_q;
    assign s_axi_rvalid = rValid_q;
    assign s_axi_rdata = rData_q;
    assign s_axi_rresp = rResp_q;
    assign rdIdx = s_axi_araddr[7:2];

    always_comb begin
        rValid_d = rValid_q;
        rData_d = rData_q;
        rResp_d = rResp_q;
        if (rValid_q && s_axi_rready) begin
            rValid_d = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rValid_d = 1'b1;
            rResp_d = `CUC_RESP_OKAY;
            rData_d = 32'h0000_0000;
            case (rdIdx)
                `CUC_IDX_DIFF: rData_d = {24'h00_0000, pairDiff_q};
                `CUC_IDX_JOIN: rData_d = {16'h0000, join_q};
                `CUC_IDX_SYNC: rData_d = {16'h0000, sync_q};
                `CUC_IDX_TOGU: rData_d = {16'h0000, togU_q};
                `CUC_IDX_LOAD: rData_d = 32'h0000_0000;
                `CUC_IDX_BVAL: rData_d = {16'h0000, bcastVal_q};
                default: begin
                    if (rdIdx >= `CUC_IDX_CH0 && rdIdx <= `CUC_IDX_CH15) begin
                        rData_d[CODE_W-1:0] = out_q[rdIdx[3:0]];
                    end else begin
                        rResp_d = `CUC_RESP_DECERR;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rValid_q <= 1'b0;
            rData_q <= 32'h0000_0000;
            rResp_q <= `CUC_RESP_OKAY;
        end else begin
            rValid_q <= rValid_d;
            rData_q <= rData_d;
            rResp_q <= rResp_d;
        end
    end

endmodule // cuc_top

// ---- logic/cuc_params.svh ----
// What this block does
// - Joined channel takes broadcast value on broadcast
// - Any differential pair: broadcast not applied to channels, value still stored in broadcast register
// - Non-joined channel unchanged by broadcast
// - Sync channel holds code until load trigger
// - Async channel applies written code immediately
// - Sync select at index 06h, reset 0000h
// - Upper toggle select at index 07h, reset 0000h
// - Broadcast join at index 05h, reset FFFFh
// - Any of eight pair bits suppresses broadcast
`ifndef CUC_PARAMS_SVH
`define CUC_PARAMS_SVH

// Register indices; byte address is four times the index
`define CUC_IDX_DIFF 6'h04
`define CUC_IDX_JOIN 6'h05
`define CUC_IDX_SYNC 6'h06
`define CUC_IDX_TOGU 6'h07
`define CUC_IDX_LOAD 6'h0E
`define CUC_IDX_BVAL 6'h0F
`define CUC_IDX_CH0 6'h10
`define CUC_IDX_CH15 6'h1F

`define CUC_RST_DIFF 8'h00
`define CUC_RST_JOIN 16'hFFFF
`define CUC_RST_SYNC 16'h0000
`define CUC_RST_TOGU 16'h0000
`define CUC_LOAD_BIT 0

`define CUC_RESP_OKAY 2'h0
`define CUC_RESP_DECERR 2'h3

`endif

// ---- logic/cuc_pkg.sv ----
package cuc_pkg;

    typedef enum logic [1:0] {
        CUC_WR_IDLE = 2'b01,
        CUC_WR_RESP = 2'b10
    } cuc_wr_e;

    typedef logic [15:0] cuc_chmask_t;

endpackage

// ---- dv/cuc_checker.sv ----
`timescale 1ns/100ps
`include "cuc_params.svh"
module cuc_checker #(
    parameter int CODE_W = 16,
    parameter int NCH = 16,
    parameter int ADDR_W = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic loadTrigger,
    input wire logic [NCH*CODE_W-1:0] chanOut,
    input wire logic broadcastBlocked
);
default clocking cb @(posedge clk); endclocking
default disable iff (rst);
logic [5:0] idxQ, idxD;
logic [31:0] wdQ, wdD;
logic [15:0] syncQ, syncD, joinQ, joinD;
logic bvQ, done, mapped;
assign done = s_axi_bvalid && !bvQ;
assign mapped = idxQ inside {[`CUC_IDX_DIFF:`CUC_IDX_TOGU], [`CUC_IDX_LOAD:`CUC_IDX_CH15]};
////////////////////////////////////////////////////////////////////////////////
// Mirror of the last write and of the join and sync selections
always_comb begin
    idxD = idxQ;
    wdD = wdQ;
    syncD = syncQ;
    joinD = joinQ;
    if (s_axi_awvalid && s_axi_awready) idxD = s_axi_awaddr[7:2];
    if (s_axi_wvalid && s_axi_wready) wdD = s_axi_wdata;
    if (done && idxQ == `CUC_IDX_SYNC) syncD = wdQ[15:0];
    if (done && idxQ == `CUC_IDX_JOIN) joinD = wdQ[15:0];
end
always_ff @(posedge clk) begin
    idxQ <= rst ? 6'h00 : idxD;
    wdQ <= rst ? 32'h0000_0000 : wdD;
    syncQ <= rst ? `CUC_RST_SYNC : syncD;
    joinQ <= rst ? `CUC_RST_JOIN : joinD;
    bvQ <= rst ? 1'b0 : s_axi_bvalid;
end
////////////////////////////////////////////////////////////////////////////////
resp_code_a: assert property (done |-> s_axi_bresp == (mapped ? 2'h0 : 2'h3))
    else $error("write response code wrong");
resp_rise_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> s_axi_bvalid && !s_axi_awready) else $error("write response late");
pair_block_a: assert property (done && idxQ == `CUC_IDX_DIFF
    |-> ##[0:1] broadcastBlocked == (|wdQ[7:0])) else $error("blocked flag wrong");
bcast_block_a: assert property (done && idxQ == `CUC_IDX_BVAL && broadcastBlocked
    && !$past(loadTrigger) |-> $stable(chanOut)) else $error("blocked broadcast changed outputs");
for (genvar n = 0; n < NCH; n++) begin : g_ch
    bcast_join_a: assert property (done && idxQ == `CUC_IDX_BVAL && !broadcastBlocked
        && joinQ[n] && !syncQ[n] |-> chanOut[n*CODE_W +: CODE_W] == wdQ[CODE_W-1:0])
        else $error("joined channel missed broadcast");
    bcast_skip_a: assert property (done && idxQ == `CUC_IDX_BVAL && !joinQ[n]
        && !$past(loadTrigger) |-> $stable(chanOut[n*CODE_W +: CODE_W]))
        else $error("unjoined channel changed");
    code_async_a: assert property (done && idxQ == `CUC_IDX_CH0 + n && !syncQ[n]
        |-> chanOut[n*CODE_W +: CODE_W] == wdQ[CODE_W-1:0]) else $error("async code late");
    code_hold_a: assert property (done && idxQ == `CUC_IDX_CH0 + n && syncQ[n]
        && !$past(loadTrigger) |-> $stable(chanOut[n*CODE_W +: CODE_W]))
        else $error("sync code applied early");
end
endmodule // cuc_checker
bind cuc_top cuc_checker #(.CODE_W(CODE_W), .NCH(NCH), .ADDR_W(ADDR_W)) chk (.clk(clk),
    .rst(rst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .loadTrigger(loadTrigger), .chanOut(chanOut), .broadcastBlocked(broadcastBlocked));

// ---- dv/cuc_host.sv ----
`timescale 1ns/100ps
module cuc_host (
    input wire logic clk,
    output logic [7:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [7:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0000_0000_0000;
    s_axi_wstrb = 4'hF;
end
// Released address and data lines show the inverse of the last value
// Handshakes are judged on settled values half a cycle before the edge that takes them
task automatic wr(input logic [5:0] i, input logic [31:0] d, input logic [3:0] s,
                  output logic [1:0] r);
    int n;
    logic awTake, wTake, bTake;
    @(posedge clk);
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {i, 2'b00, d, s};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    for (n = 0; n < 64; n++) begin
        @(negedge clk);
        awTake = s_axi_awvalid && s_axi_awready;
        wTake = s_axi_wvalid && s_axi_wready;
        bTake = s_axi_bvalid;
        r = s_axi_bresp;
        @(posedge clk);
        if (awTake) {s_axi_awvalid, s_axi_awaddr} <= {1'b0, ~i, 2'b11};
        if (wTake) {s_axi_wvalid, s_axi_wdata} <= {1'b0, ~d};
        if (bTake) break;
    end
    s_axi_bready <= 1'b0;
    if (n == 64) begin
        testbench.fails++;
        testbench.final_report();
    end
endtask
task automatic rd(input logic [5:0] i, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic arTake, rTake;
    @(posedge clk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {i, 2'b00, 2'b11};
    for (n = 0; n < 64; n++) begin
        @(negedge clk);
        arTake = s_axi_arvalid && s_axi_arready;
        rTake = s_axi_rvalid;
        {d, r} = {s_axi_rdata, s_axi_rresp};
        @(posedge clk);
        if (arTake) {s_axi_arvalid, s_axi_araddr} <= {1'b0, ~i, 2'b11};
        if (rTake) break;
    end
    s_axi_rready <= 1'b0;
    if (n == 64) begin
        testbench.fails++;
        testbench.final_report();
    end
endtask
endmodule // cuc_host

// ---- dv/testbench.sv ----
`timescale 1ns/100ps
`include "cuc_params.svh"
module testbench;
logic clk, rst, loadTrigger, broadcastBlocked;
logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
logic [7:0] s_axi_awaddr, s_axi_araddr;
logic [31:0] s_axi_wdata, s_axi_rdata;
logic [3:0] s_axi_wstrb;
logic [1:0] s_axi_bresp, s_axi_rresp;
logic [255:0] chanOut;
int fails, compares;
cuc_top DUT (.*);
cuc_host host (.*);
initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
end
task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
        fails++;
        $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
endtask
task automatic wrc(input logic [5:0] i, input logic [31:0] d, input logic [1:0] e,
                   input logic [3:0] s = 4'hF);
    logic [1:0] r;
    host.wr(i, d, s, r);
    chk("bresp", {30'h0, e}, {30'h0, r});
endtask
task automatic rdc(input logic [5:0] i, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    host.rd(i, d, r);
    chk("rdata", e, d);
    chk("rresp", {30'h0, er}, {30'h0, r});
endtask
task automatic chans(input logic [15:0] lo, input logic [15:0] hi);
    for (int n = 0; n < 16; n++) chk("chanOut", n < 8 ? lo : hi, chanOut[16*n +: 16]);
endtask
////////////////////////////////////////////////////////////////////////////////
task automatic t_map;
    rdc(`CUC_IDX_JOIN, 32'h0000_FFFF, 2'h0);
    rdc(`CUC_IDX_SYNC, 32'h0000_0000, 2'h0);
    rdc(`CUC_IDX_TOGU, 32'h0000_0000, 2'h0);
    rdc(6'h08, 32'h0000_0000, 2'h3);
    wrc(`CUC_IDX_TOGU, 32'h0000_1234, 2'h0);
    rdc(`CUC_IDX_TOGU, 32'h0000_1234, 2'h0);
    wrc(`CUC_IDX_TOGU, 32'h0000_FFFF, 2'h0, 4'h1);
    rdc(`CUC_IDX_TOGU, 32'h0000_12FF, 2'h0);
    wrc(`CUC_IDX_SYNC, 32'h0000_A5A5, 2'h0);
    rdc(`CUC_IDX_SYNC, 32'h0000_A5A5, 2'h0);
    wrc(6'h3F, 32'h0000_0001, 2'h3);
    wrc(`CUC_IDX_SYNC, 32'h0000_0000, 2'h0);
endtask
task automatic t_bcast;
    wrc(`CUC_IDX_DIFF, 32'h0000_0000, 2'h0);
    wrc(`CUC_IDX_JOIN, 32'h0000_00FF, 2'h0);
    wrc(`CUC_IDX_BVAL, 32'h0000_BEEF, 2'h0);
    chans(16'hBEEF, 16'h0000);
    wrc(`CUC_IDX_DIFF, 32'h0000_0080, 2'h0);
    @(posedge clk);
    chk("blocked", 32'h0000_0001, {31'h0, broadcastBlocked});
    wrc(`CUC_IDX_BVAL, 32'h0000_7777, 2'h0);
    chans(16'hBEEF, 16'h0000);
    rdc(`CUC_IDX_BVAL, 32'h0000_7777, 2'h0);
    wrc(`CUC_IDX_DIFF, 32'h0000_0001, 2'h0);
    chk("blocked", 32'h0000_0001, {31'h0, broadcastBlocked});
    wrc(`CUC_IDX_DIFF, 32'h0000_0000, 2'h0);
    chk("blocked", 32'h0000_0000, {31'h0, broadcastBlocked});
endtask
task automatic t_sync;
    wrc(`CUC_IDX_SYNC, 32'h0000_0003, 2'h0);
    wrc(`CUC_IDX_CH0, 32'h0000_1234, 2'h0);
    wrc(`CUC_IDX_CH0 + 6'h01, 32'h0000_9ABC, 2'h0);
    wrc(`CUC_IDX_CH0 + 6'h02, 32'h0000_5678, 2'h0);
    chk("chan0", 32'h0000_BEEF, {16'h0, chanOut[15:0]});
    chk("chan2", 32'h0000_5678, {16'h0, chanOut[47:32]});
    rdc(`CUC_IDX_CH0 + 6'h02, 32'h0000_5678, 2'h0);
    loadTrigger <= 1'b1;
    @(posedge clk);
    loadTrigger <= 1'b0;
    @(posedge clk);
    chk("chan01", 32'h9ABC_1234, chanOut[31:0]);
    wrc(`CUC_IDX_CH0, 32'h0000_4321, 2'h0);
    chk("chan0", 32'h0000_1234, {16'h0, chanOut[15:0]});
    wrc(`CUC_IDX_LOAD, 32'h0000_0001, 2'h0);
    chk("chan0", 32'h0000_4321, {16'h0, chanOut[15:0]});
endtask
////////////////////////////////////////////////////////////////////////////////
initial begin
    {rst, loadTrigger, fails, compares} = {2'b10, 32'd0, 32'd0};
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_map;
    t_bcast;
    t_sync;
    final_report;
end
task final_report;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
endtask
endmodule // testbench
